//--- core/aef_consts.svh
// constants for the converter fault flag block
`ifndef AEF_CONSTS_SVH
`define AEF_CONSTS_SVH
`define AEF_DATA_W 24
`define AEF_STAT_W 8
`define AEF_ST_RDYN 7
`define AEF_ST_CONV 6
`define AEF_ST_CSUM 5
`define AEF_ST_REG 4
`define AEF_ST_CH_HI 1
`define AEF_ST_CH_LO 0
`define AEF_STAT_RST 8'h80
`define AEF_ALL_ONES 24'hFFFFFF
`define AEF_ALL_ZERO 24'h000000
`define AEF_PAD_ZERO 8'h00
`define AEF_SUM_W 16
`define AEF_SUM_POLY 16'h1021
`define AEF_SUM_INIT 16'hFFFF
`endif

//--- core/aef_pkg.sv
// types for the converter fault flag block
package aef_pkg;
  typedef enum logic [1:0] {
    AEF_PIN_OFF = 2'b00,
    AEF_PIN_IN = 2'b01,
    AEF_PIN_OD = 2'b10,
    AEF_PIN_GPO = 2'b11
  } aef_pin_mode_t;
endpackage

//--- core/aef_error_flags.sv
// fault flags, fault pin and status append of the converter
//
// Function
// - overrange or underrange result sets the conversion fault flag.
// - overvoltage outputs all ones, undervoltage outputs all zeros.
// - conversion fault clears only after the input fault goes away.
// - data register reads leave the conversion fault flag alone.
// - a write with a bad checksum sets the write checksum fault.
// - explicit status read clears the write checksum fault.
// - watch enabled: checksum the registers, flag any changed bit.
// - register corruption flag clears only when watch is disabled.
// - data, status and interface mode registers are not watched.
// - mode 10: open-drain pin shows inverted OR of three flags.
// - mode 01: inverted pin input ORs into conversion fault.
// - mode 01: pin level bit follows the pin.
// - mode 00: pin input and output both disabled.
// - mode 11: pin is a general-purpose output.
// - general-purpose output drives the pin level bit value.
// - append enabled: status follows every conversion result.
// - low two appended status bits give the result channel.
`timescale 1ns/10ps
`include "aef_consts.svh"

module aef_error_flags #(
  parameter int REG_BITS = 64
) (
  input wire logic clock, // 50 MHz master clock
  input wire logic resetn, // async reset
  input wire logic resultValid, // result latched, pulse
  input wire logic [`AEF_DATA_W-1:0] resultData, // raw result
  input wire logic [1:0] resultChan, // channel of result
  input wire logic overRange, // result out of range high
  input wire logic underRange, // result out of range low
  input wire logic overVoltage, // input over limit, level
  input wire logic underVoltage, // input under limit, level
  input wire logic dataRead, // data register read, pulse
  input wire logic statusRead, // status register read, pulse
  input wire logic wrSumDone, // write checksum checked, pulse
  input wire logic wrSumBad, // checksum mismatch with done
  input wire logic regWatchEn, // interface mode watch bit
  input wire logic appendEn, // interface mode append bit
  input wire aef_pkg::aef_pin_mode_t pinFunc, // pin config mode
  input wire logic pinLevelWr, // written pin level bit
  input wire logic [REG_BITS-1:0] watchedRegs, // watched bits
  input wire logic faultPinIn, // fault pin input level
  output logic convFault_q, // conversion fault flag
  output logic sumFault_q, // write checksum fault flag
  output logic regFault_q, // register corruption flag
  output logic [`AEF_STAT_W-1:0] statusByte_q, // status register
  output logic faultPinLevel_q, // pin level bit readback
  output logic faultPinOut_q, // pin output value
  output logic faultPinOeN_q, // pin output enable, low drives
  output logic outValid_q, // result word valid, pulse
  output logic [`AEF_DATA_W+`AEF_STAT_W-1:0] outData_q, // word out
  output logic outHasStatus_q // status byte appended
);
  import aef_pkg::*;

  // ----------------------------------------------------------------
  // register checksum
  // ----------------------------------------------------------------
  function automatic logic [`AEF_SUM_W-1:0] regSum(
    input logic [REG_BITS-1:0] r
  );
    logic [`AEF_SUM_W-1:0] c;
    logic fb;
    c = `AEF_SUM_INIT;
    for (int i = 0; i < REG_BITS; i++) begin
      fb = c[`AEF_SUM_W-1] ^ r[i];
      c = {c[`AEF_SUM_W-2:0], 1'b0} ^ (fb ? `AEF_SUM_POLY : '0);
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  logic pinMeta_q;
  logic pinSync_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
    end else begin
      pinMeta_q <= faultPinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // idle high pin means no external fault
  logic extFault;
  assign extFault = (pinFunc == AEF_PIN_IN) && !pinSync_q;

  // ----------------------------------------------------------------
  // conversion fault
  // ----------------------------------------------------------------
  logic convSet;
  logic convHold;
  logic convFault_d;
  assign convSet = (resultValid && (overRange || underRange)) || extFault;
  // no read path here, so data reads cannot disturb it
  assign convHold = overVoltage || underVoltage || extFault;
  assign convFault_d = convSet || (convFault_q && convHold);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      convFault_q <= 1'b0;
    end else begin
      convFault_q <= convFault_d;
    end
  end

  // ----------------------------------------------------------------
  // write checksum fault
  // ----------------------------------------------------------------
  logic sumSet;
  logic sumFault_d;
  assign sumSet = wrSumDone && wrSumBad;
  // set beats a read in the same cycle
  assign sumFault_d = sumSet || (sumFault_q && !statusRead);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sumFault_q <= 1'b0;
    end else begin
      sumFault_q <= sumFault_d;
    end
  end

  // ----------------------------------------------------------------
  // register watch
  // ----------------------------------------------------------------
  // excluded registers are simply not wired into watchedRegs
  logic armed_q;
  logic [`AEF_SUM_W-1:0] refSum_q;
  logic [`AEF_SUM_W-1:0] curSum;
  logic regFault_d;
  assign curSum = regSum(watchedRegs);
  assign regFault_d = regWatchEn &&
    (regFault_q || (armed_q && curSum != refSum_q));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      armed_q <= 1'b0;
      refSum_q <= `AEF_SUM_INIT;
    end else if (!regWatchEn) begin
      armed_q <= 1'b0;
    end else if (!armed_q) begin
      armed_q <= 1'b1;
      refSum_q <= curSum;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regFault_q <= 1'b0;
    end else begin
      regFault_q <= regFault_d;
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  logic rdyN_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdyN_q <= 1'b1;
    end else if (resultValid) begin
      rdyN_q <= 1'b0;
    end else if (dataRead) begin
      rdyN_q <= 1'b1;
    end
  end

  logic [1:0] chan_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      chan_q <= 2'h0;
    end else if (resultValid) begin
      chan_q <= resultChan;
    end
  end

  function automatic logic [`AEF_STAT_W-1:0] packStat(
    input logic rdyN, input logic cf, input logic sf, input logic rf,
    input logic [1:0] ch
  );
    logic [`AEF_STAT_W-1:0] s;
    s = '0;
    s[`AEF_ST_RDYN] = rdyN;
    s[`AEF_ST_CONV] = cf;
    s[`AEF_ST_CSUM] = sf;
    s[`AEF_ST_REG] = rf;
    s[`AEF_ST_CH_HI:`AEF_ST_CH_LO] = ch;
    return s;
  endfunction

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      statusByte_q <= `AEF_STAT_RST;
    end else begin
      statusByte_q <= packStat(rdyN_q, convFault_q, sumFault_q,
                               regFault_q, chan_q);
    end
  end

  // ----------------------------------------------------------------
  // fault pin
  // ----------------------------------------------------------------
  logic anyFault;
  assign anyFault = convFault_q || sumFault_q || regFault_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      faultPinOut_q <= 1'b1;
      faultPinOeN_q <= 1'b1;
      faultPinLevel_q <= 1'b0;
    end else begin
      case (pinFunc)
        AEF_PIN_OFF: begin
          faultPinOut_q <= 1'b1;
          faultPinOeN_q <= 1'b1;
          faultPinLevel_q <= pinLevelWr;
        end
        AEF_PIN_IN: begin
          faultPinOut_q <= 1'b1;
          faultPinOeN_q <= 1'b1;
          faultPinLevel_q <= pinSync_q;
        end
        AEF_PIN_OD: begin
          // open drain: only ever pulls low, released otherwise
          faultPinOut_q <= 1'b0;
          faultPinOeN_q <= !anyFault;
          faultPinLevel_q <= pinLevelWr;
        end
        AEF_PIN_GPO: begin
          faultPinOut_q <= pinLevelWr;
          faultPinOeN_q <= 1'b0;
          faultPinLevel_q <= pinLevelWr;
        end
        default: begin
          faultPinOut_q <= 1'b1;
          faultPinOeN_q <= 1'b1;
          faultPinLevel_q <= pinLevelWr;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result stream
  // ----------------------------------------------------------------
  logic [`AEF_DATA_W-1:0] clamped;
  logic [`AEF_STAT_W-1:0] latchStat;
  always_comb begin
    clamped = resultData;
    if (overVoltage) begin
      clamped = `AEF_ALL_ONES;
    end else if (underVoltage) begin
      clamped = `AEF_ALL_ZERO;
    end
  end
  // next-state flags so this very result's fault is shown
  assign latchStat = packStat(1'b0, convFault_d, sumFault_d, regFault_d,
                              resultChan);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      outValid_q <= 1'b0;
      outData_q <= '0;
      outHasStatus_q <= 1'b0;
    end else begin
      outValid_q <= resultValid;
      if (resultValid) begin
        outHasStatus_q <= appendEn;
        if (appendEn) begin
          outData_q <= {clamped, latchStat};
        end else begin
          outData_q <= {`AEF_PAD_ZERO, clamped};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  conv_set_a: assert property (
    resultValid && (overRange || underRange) |=> convFault_q)
    else $error("range result did not set conversion fault");
  data_clamp_a: assert property (
    resultValid && overVoltage && !appendEn |=>
      outValid_q && outData_q[`AEF_DATA_W-1:0] == `AEF_ALL_ONES)
    else $error("overvoltage result not all ones");
  conv_clear_a: assert property (
    $fell(convFault_q) |-> !$past(overVoltage) && !$past(underVoltage))
    else $error("conversion fault cleared while input faulty");
  conv_read_a: assert property (
    dataRead && convFault_q && overVoltage |=> convFault_q)
    else $error("data read disturbed conversion fault");
  sum_set_a: assert property (
    wrSumDone && wrSumBad ##1 !statusRead |=> sumFault_q)
    else $error("bad write checksum not flagged");
  sum_clear_a: assert property (
    statusRead && !(wrSumDone && wrSumBad) |=> !sumFault_q)
    else $error("status read did not clear checksum fault");
  reg_clear_a: assert property (
    !regWatchEn |=> !regFault_q)
    else $error("corruption flag held with watch off");
  reg_hold_a: assert property (
    regFault_q && regWatchEn |=> regFault_q)
    else $error("corruption flag cleared with watch on");
  pin_od_a: assert property (
    pinFunc == AEF_PIN_OD && anyFault |=> !faultPinOeN_q && !faultPinOut_q)
    else $error("open-drain pin not pulled on fault");
  pin_ext_a: assert property (
    (pinFunc == AEF_PIN_IN && !faultPinIn)[*3] |=> convFault_q)
    else $error("external fault not merged");
  pin_gpo_a: assert property (
    pinFunc == AEF_PIN_GPO |=>
      !faultPinOeN_q && faultPinOut_q == $past(pinLevelWr))
    else $error("general output level wrong");
  pin_off_a: assert property (
    pinFunc == AEF_PIN_OFF |=> faultPinOeN_q)
    else $error("disabled pin is driven");
  append_ch_a: assert property (
    resultValid && appendEn |=> outHasStatus_q &&
      outData_q[`AEF_ST_CH_HI:`AEF_ST_CH_LO] == $past(resultChan))
    else $error("appended channel wrong");

endmodule // aef_error_flags

//--- test/aef_pin_partner.sv
// open-drain fault wire with pull-up and an external fault source
`timescale 1ns/10ps
module aef_pin_partner (
  input wire logic pinOut, // design pin value
  input wire logic pinOeN, // design enable, low drives
  input wire logic extFault, // external part pulls the wire low
  output logic pinWire // resolved wire level
);
  // pull-up wins only when nobody pulls low
  assign pinWire = (extFault || (!pinOeN && !pinOut)) ? 1'b0 : 1'b1;
endmodule // aef_pin_partner

//--- test/tb_adc_error_flag_logic.sv
// self-checking bench for the converter fault flag block
`timescale 1ns/10ps
`include "aef_consts.svh"
module tb_adc_error_flag_logic;
  import aef_pkg::*;
  logic clock, resetn, resultValid, overRange, underRange;
  logic overVoltage, underVoltage, dataRead, statusRead;
  logic wrSumDone, wrSumBad, regWatchEn, appendEn, pinLevelWr;
  logic extFault, faultPinIn, convFault_q, sumFault_q, regFault_q;
  logic faultPinLevel_q, faultPinOut_q, faultPinOeN_q;
  logic outValid_q, outHasStatus_q;
  logic [1:0] resultChan;
  logic [`AEF_DATA_W-1:0] resultData;
  logic [63:0] watchedRegs;
  logic [`AEF_STAT_W-1:0] statusByte_q;
  logic [31:0] outData_q;
  aef_pin_mode_t pinFunc;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  aef_error_flags #(.REG_BITS(64)) dut_u (.clock(clock), .resetn(resetn),
    .resultValid(resultValid), .resultData(resultData),
    .resultChan(resultChan), .overRange(overRange),
    .underRange(underRange), .overVoltage(overVoltage),
    .underVoltage(underVoltage), .dataRead(dataRead),
    .statusRead(statusRead), .wrSumDone(wrSumDone), .wrSumBad(wrSumBad),
    .regWatchEn(regWatchEn), .appendEn(appendEn), .pinFunc(pinFunc),
    .pinLevelWr(pinLevelWr), .watchedRegs(watchedRegs),
    .faultPinIn(faultPinIn), .convFault_q(convFault_q),
    .sumFault_q(sumFault_q), .regFault_q(regFault_q),
    .statusByte_q(statusByte_q), .faultPinLevel_q(faultPinLevel_q),
    .faultPinOut_q(faultPinOut_q), .faultPinOeN_q(faultPinOeN_q),
    .outValid_q(outValid_q), .outData_q(outData_q),
    .outHasStatus_q(outHasStatus_q));
  aef_pin_partner part_u (.pinOut(faultPinOut_q), .pinOeN(faultPinOeN_q),
    .extFault(extFault), .pinWire(faultPinIn));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic result(input logic [23:0] d, input logic [1:0] ch,
      input logic ovr, input logic und);
    @(posedge clock);
    resultValid <= 1'b1;
    resultData <= d;
    resultChan <= ch;
    overRange <= ovr;
    underRange <= und;
    @(posedge clock);
    resultValid <= 1'b0;
    overRange <= 1'b0;
    underRange <= 1'b0;
    @(negedge clock);
  endtask
  task automatic sumWrite(input logic bad);
    @(posedge clock);
    wrSumDone <= 1'b1;
    wrSumBad <= bad;
    @(posedge clock);
    wrSumDone <= 1'b0;
    wrSumBad <= 1'b0;
    @(negedge clock);
  endtask
  task automatic readStat;
    @(posedge clock);
    statusRead <= 1'b1;
    dataRead <= 1'b1;
    @(posedge clock);
    statusRead <= 1'b0;
    dataRead <= 1'b0;
    @(negedge clock);
  endtask
  task automatic t_conv;
    @(posedge clock);
    overVoltage <= 1'b1;
    result(24'h123456, 2'h0, 1'b1, 1'b0);
    chk(outData_q[23:0], `AEF_ALL_ONES);
    chk(convFault_q, 1);
    readStat;
    look(1);
    chk(convFault_q, 1);
    @(posedge clock);
    overVoltage <= 1'b0;
    underVoltage <= 1'b1;
    result(24'h654321, 2'h1, 1'b0, 1'b1);
    chk(outData_q[23:0], `AEF_ALL_ZERO);
    chk(convFault_q, 1);
    @(posedge clock);
    underVoltage <= 1'b0;
    look(1);
    chk(convFault_q, 0);
    $display("test conv done");
  endtask
  task automatic t_sum;
    sumWrite(1'b0);
    chk(sumFault_q, 0);
    sumWrite(1'b1);
    chk(sumFault_q, 1);
    readStat;
    chk(sumFault_q, 0);
    $display("test sum done");
  endtask
  task automatic t_watch;
    @(posedge clock);
    watchedRegs <= watchedRegs ^ 64'h1;
    look(2);
    chk(regFault_q, 0);
    @(posedge clock);
    regWatchEn <= 1'b1;
    repeat (3) @(posedge clock);
    watchedRegs <= watchedRegs ^ 64'h8000000000000000;
    look(1);
    chk(regFault_q, 1);
    readStat;
    chk(regFault_q, 1);
    @(posedge clock);
    regWatchEn <= 1'b0;
    look(1);
    chk(regFault_q, 0);
    $display("test watch done");
  endtask
  task automatic t_pin;
    @(posedge clock);
    pinFunc <= AEF_PIN_OD;
    sumWrite(1'b1);
    look(2);
    chk({faultPinOeN_q, faultPinIn}, 2'b00);
    chk(statusByte_q[`AEF_ST_CSUM], 1);
    readStat;
    look(2);
    chk({faultPinOeN_q, faultPinIn}, 2'b11);
    @(posedge clock);
    pinFunc <= AEF_PIN_GPO;
    pinLevelWr <= 1'b1;
    look(2);
    chk({faultPinOeN_q, faultPinOut_q}, 2'b01);
    @(posedge clock);
    pinLevelWr <= 1'b0;
    look(2);
    chk({faultPinOut_q, convFault_q}, 2'b00);
    @(posedge clock);
    pinFunc <= AEF_PIN_OFF;
    extFault <= 1'b1;
    look(4);
    chk({faultPinOeN_q, convFault_q}, 2'b10);
    @(posedge clock);
    pinFunc <= AEF_PIN_IN;
    extFault <= 1'b0;
    look(3);
    @(posedge clock);
    extFault <= 1'b1;
    look(1);
    chk(convFault_q, 0);
    look(2);
    chk({convFault_q, faultPinLevel_q}, 2'b10);
    @(posedge clock);
    extFault <= 1'b0;
    look(4);
    chk({convFault_q, faultPinLevel_q}, 2'b01);
    $display("test pin done");
  endtask
  task automatic t_append;
    @(posedge clock);
    appendEn <= 1'b1;
    resultValid <= 1'b1;
    resultData <= 24'hA5A5A5;
    resultChan <= 2'h1;
    @(posedge clock);
    resultData <= 24'h5A5A5A;
    resultChan <= 2'h2;
    @(negedge clock);
    chk({outValid_q, outHasStatus_q}, 2'b11);
    chk(outData_q, 32'hA5A5A501);
    @(posedge clock);
    resultValid <= 1'b0;
    @(negedge clock);
    chk(outData_q, 32'h5A5A5A02);
    look(0);
    chk(outValid_q, 0);
    result(24'h0F0F0F, 2'h3, 1'b1, 1'b0);
    chk(outData_q, 32'h0F0F0F43);
    @(posedge clock);
    appendEn <= 1'b0;
    result(24'h111111, 2'h0, 1'b0, 1'b0);
    chk(outHasStatus_q, 0);
    chk(outData_q, 32'h00111111);
    $display("test append done");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // the whole run takes under a hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    {resetn, resultValid, overRange, underRange, overVoltage} = 5'h00;
    {underVoltage, dataRead, statusRead, wrSumDone, wrSumBad} = 5'h00;
    {regWatchEn, appendEn, pinLevelWr, extFault} = 4'h0;
    resultChan = 2'h0;
    resultData = 24'h000000;
    watchedRegs = 64'h0123456789ABCDEF;
    pinFunc = AEF_PIN_OFF;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    t_conv;
    t_sum;
    t_watch;
    t_pin;
    t_append;
    finish_test;
  end
endmodule // tb_adc_error_flag_logic
